// ==== htq_pkg.sv ====
// Shared constants and types for the host transmit queue path.
// Assumes a single 125 MHz clock and synchronous active-high reset on both ends.
package htq_pkg;
  localparam logic [8:0] REG_TX_CONTROL = 9'h170;
  localparam logic [8:0] REG_TX_FREE = 9'h178;
  localparam logic [8:0] REG_TXQ_COMMAND = 9'h180;
  localparam logic [8:0] REG_RXQ_CONTROL = 9'h182;
  localparam logic [8:0] REG_TX_DATA_PTR = 9'h184;
  localparam logic [8:0] REG_DATA_PORT = 9'h1A0;
  localparam logic [8:0] REG_IRQ_MASK = 9'h190;
  localparam logic [8:0] REG_IRQ_FLAGS = 9'h192;
  localparam logic [8:0] REG_NEXT_SPACE = 9'h19E;
  localparam int TXC_FLOW = 3;
  localparam int TXC_PAD = 2;
  localparam int TXC_CRC = 1;
  localparam int TXC_ENABLE = 0;
  localparam int TXC_CSUM_LO = 5;
  localparam int TXC_CSUM_HI = 8;
  localparam logic [15:0] TXC_WRITE_MASK = 16'h01EF;
  localparam int TQC_ENQUEUE = 0;
  localparam int TQC_SPACE_REQ = 1;
  localparam int RQC_DMA_START = 3;
  localparam int TDP_AUTO_INC = 14;
  localparam int IRQ_TX_DONE = 14;
  localparam int IRQ_TX_SPACE = 6;
  localparam logic [15:0] IRQ_CLEAR_ALL = 16'hFFFF;
  localparam int CW_COMPLETION_IRQ = 15;
  localparam int CW_TAG_HI = 5;
  localparam int LEN_HI = 10;
  localparam logic [12:0] TXQ_BYTES = 13'h1800;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_DATA_MAX = 2000;
  localparam int TX_WORD_TIME_NS = 80;
  localparam int CLOCK_NS = 8;
  localparam int TX_WORD_CYCLES = (TX_WORD_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
  typedef enum logic [1:0] {HTQ_TX_IDLE, HTQ_TX_CTRL, HTQ_TX_LEN, HTQ_TX_DATA} htq_tx_state_t;
endpackage : htq_pkg

// ==== htq_bus_if.sv ====
// Generic 16-bit host bus between the host end and the device end.
// Assumes both ends share one clock; accesses complete in one cycle.
`timescale 1ns/1ns
`default_nettype none
interface htq_bus_if;
  logic [8:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic big_endian;
  logic irq;
  modport device (input addr, wr, rd, wdata, big_endian, output rdata, irq);
  modport host (output addr, wr, rd, wdata, big_endian, input rdata, irq);
endinterface : htq_bus_if
`default_nettype wire

// ==== htq_fifo.sv ====
// Parameterised valid/ready FIFO used as the device's transmit queue store.
// Assumes single clock; full and empty are exact.
`timescale 1ns/1ns
`default_nettype none
module htq_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } htq_fifo_state_t;
  htq_fifo_state_t s;
  htq_fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  assign o_ready = s.count != (AW+1)'(DEPTH);
  assign o_valid = s.count != '0;
  assign o_data = mem[s.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  always_comb
  begin
    next_s = s;
    if (push)
      next_s.wp = s.wp + 1'b1;
    if (pop)
      next_s.rp = s.rp + 1'b1;
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      s <= '0;
    else
      s <= next_s;
    if (push)
      mem[s.wp] <= i_data;
  end
endmodule : htq_fifo
`default_nettype wire

// ==== htq_device.sv ====
// Device end: transmit registers, queue accounting and frame drain to the MAC side.
// Assumes the host end drives the bus interface on the same clock.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Control bits enable flow control and padding
// - Control bits enable CRC and transmitter
// - Control holds four checksum generation enables
// - Read-only register reports free queue bytes
// - Manual enqueue queues one prepared frame
// - Enqueue bit clears when frame transmitted
// - Host waits for enqueue clear before next
// - Space request raises space-available flag
// - Space request self-clears; host waits readback
// - DMA start bit opens queue data access
// - Auto-increment advances pointer per data access
// - Mask bit unmasks transmit-completion interrupt
// - Mask bit unmasks space-available interrupt
// - Writing ones clears interrupt flags
// - Host programs space request in dwords
// - Frame write order: control, length, data
// - Host pads data to dword boundary
// - Receive frame: status, length, then data
// - Receive data includes CRC bytes
// - Receive data area at most 2000 bytes
// - Big-endian mode swaps header word bytes
// - Control word: completion flag and frame tag
// - Length word low eleven bits, nonzero
module htq_device
  import htq_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Host bus
  htq_bus_if.device bus,
  // Transmit side toward the MAC
  output logic o_tx_valid,
  output logic [15:0] o_tx_data,
  output logic o_tx_last,
  output logic [5:0] o_tx_tag,
  output logic [8:0] o_tx_options,
  // Receive header words offered to the host
  input wire logic [15:0] i_rx_status,
  input wire logic [10:0] i_rx_length,
  output logic [15:0] o_rx_status_word,
  output logic [15:0] o_rx_length_word,
  output logic o_rx_length_error
);
  import htq_pkg::*;
  typedef struct packed {
    logic [15:0] tx_control;
    logic enqueue;
    logic space_req;
    logic dma_start;
    logic auto_inc;
    logic [10:0] data_ptr;
    logic [15:0] irq_mask;
    logic [15:0] irq_flags;
    logic [15:0] space_request;
    logic [12:0] free_bytes;
    logic [12:0] frame_bytes;
    htq_tx_state_t tx_state;
    logic completion_irq_request;
    logic [5:0] tx_frame_tag;
    logic [10:0] words_left;
    logic [12:0] release_bytes;
    logic [3:0] pace;
    logic [15:0] rdata;
    logic irq;
    logic tx_valid;
    logic [15:0] tx_data;
    logic tx_last;
    logic [15:0] rx_status_word;
    logic [15:0] rx_length_word;
    logic rx_length_error;
  } htq_dev_state_t;
  htq_dev_state_t s;
  htq_dev_state_t next_s;
  logic data_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_out;
  logic [12:0] dword_bytes;
  logic [15:0] flag_set;
  // Data writes are only accepted while the queue window is open and the FIFO can take them.
  assign data_wr = bus.wr && bus.addr == REG_DATA_PORT && s.dma_start && fifo_in_ready;
  assign fifo_pop = fifo_out_valid && s.enqueue && s.pace == '0;
  htq_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_store (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_valid(data_wr),
    .o_ready(fifo_in_ready),
    .i_data(bus.wdata),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_out)
  );
  assign dword_bytes = {s.space_request[10:0], 2'b00};
  always_comb
  begin
    flag_set = 16'h0000;
    next_s = s;
    next_s.tx_valid = 1'b0;
    next_s.tx_last = 1'b0;
    next_s.pace = (s.pace == '0) ? 4'(TX_WORD_CYCLES - 1) : s.pace - 4'h1;
    if (data_wr)
    begin
      next_s.frame_bytes = s.frame_bytes + 13'h0002;
      if (s.auto_inc)
        next_s.data_ptr = s.data_ptr + 11'h002;
    end
    // Free space drops on each word written and returns when a frame leaves.
    next_s.free_bytes = s.free_bytes - (data_wr ? 13'h0002 : 13'h0000);
    if (fifo_pop)
    begin
      next_s.tx_valid = s.tx_state == HTQ_TX_DATA && s.tx_control[TXC_ENABLE];
      next_s.tx_data = fifo_out;
      unique case (s.tx_state)
        HTQ_TX_IDLE, HTQ_TX_CTRL:
        begin
          next_s.completion_irq_request = fifo_out[CW_COMPLETION_IRQ];
          next_s.tx_frame_tag = fifo_out[CW_TAG_HI:0];
          next_s.tx_state = HTQ_TX_LEN;
        end
        HTQ_TX_LEN:
        begin
          next_s.words_left = (fifo_out[LEN_HI:0] + 11'h003) >> 1;
          next_s.words_left[0] = 1'b0;
          next_s.release_bytes = s.frame_bytes;
          next_s.tx_state = HTQ_TX_DATA;
        end
        HTQ_TX_DATA:
        begin
          next_s.words_left = s.words_left - 11'h001;
          if (s.words_left <= 11'h001)
          begin
            next_s.tx_last = 1'b1;
            next_s.tx_state = HTQ_TX_IDLE;
            next_s.enqueue = 1'b0;
            next_s.frame_bytes = next_s.frame_bytes - s.release_bytes;
            next_s.free_bytes = next_s.free_bytes + s.release_bytes;
            if (s.completion_irq_request)
              flag_set[IRQ_TX_DONE] = 1'b1;
          end
        end
      endcase
    end
    if (s.space_req && s.free_bytes >= dword_bytes)
    begin
      next_s.space_req = 1'b0;
      flag_set[IRQ_TX_SPACE] = 1'b1;
    end
    next_s.rdata = 16'h0000;
    if (bus.rd)
    begin
      unique case (bus.addr)
        REG_TX_CONTROL: next_s.rdata = s.tx_control;
        REG_TX_FREE: next_s.rdata = {3'h0, s.free_bytes};
        REG_TXQ_COMMAND: next_s.rdata = {14'h0000, s.space_req, s.enqueue};
        REG_RXQ_CONTROL: next_s.rdata = 16'(s.dma_start) << RQC_DMA_START;
        REG_TX_DATA_PTR: next_s.rdata = {1'b0, s.auto_inc, 3'h0, s.data_ptr};
        REG_IRQ_MASK: next_s.rdata = s.irq_mask;
        REG_IRQ_FLAGS: next_s.rdata = s.irq_flags;
        REG_NEXT_SPACE: next_s.rdata = s.space_request;
        default: next_s.rdata = 16'h0000;
      endcase
    end
    if (bus.wr)
    begin
      unique case (bus.addr)
        REG_TX_CONTROL: next_s.tx_control = bus.wdata & TXC_WRITE_MASK;
        REG_TXQ_COMMAND:
        begin
          if (bus.wdata[TQC_ENQUEUE])
            next_s.enqueue = 1'b1;
          if (bus.wdata[TQC_SPACE_REQ])
            next_s.space_req = 1'b1;
        end
        REG_RXQ_CONTROL: next_s.dma_start = bus.wdata[RQC_DMA_START];
        REG_TX_DATA_PTR:
        begin
          next_s.auto_inc = bus.wdata[TDP_AUTO_INC];
          next_s.data_ptr = bus.wdata[10:0];
        end
        REG_IRQ_MASK: next_s.irq_mask = bus.wdata;
        REG_IRQ_FLAGS: next_s.irq_flags = s.irq_flags & ~bus.wdata;
        REG_NEXT_SPACE: next_s.space_request = bus.wdata;
        default: next_s.rdata = next_s.rdata;
      endcase
    end
    // A flag raised in this same cycle survives the clear, even one that was already pending.
    next_s.irq_flags = next_s.irq_flags | flag_set;
    next_s.irq = |(next_s.irq_flags & next_s.irq_mask
      & ((16'h0001 << IRQ_TX_DONE) | (16'h0001 << IRQ_TX_SPACE)));
    // Receive header words, byte-swapped when the bus runs big-endian.
    next_s.rx_status_word = bus.big_endian ? {i_rx_status[7:0], i_rx_status[15:8]} : i_rx_status;
    next_s.rx_length_word = bus.big_endian ? {i_rx_length[7:0], 5'h00, i_rx_length[10:8]}
      : {5'h00, i_rx_length};
    // Length includes CRC, so the limit applies to the full stored data.
    next_s.rx_length_error = i_rx_length > 11'(RX_DATA_MAX);
  end
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      s <= '0;
      s.free_bytes <= TXQ_BYTES;
      s.tx_state <= HTQ_TX_IDLE;
    end
    else
      s <= next_s;
  end
  assign bus.rdata = s.rdata;
  assign bus.irq = s.irq;
  assign o_tx_valid = s.tx_valid;
  assign o_tx_data = s.tx_data;
  assign o_tx_last = s.tx_last;
  assign o_tx_tag = s.tx_frame_tag;
  assign o_tx_options = s.tx_control[TXC_CSUM_HI:0];
  assign o_rx_status_word = s.rx_status_word;
  assign o_rx_length_word = s.rx_length_word;
  assign o_rx_length_error = s.rx_length_error;
endmodule : htq_device
`default_nettype wire

// ==== htq_host.sv ====
// Host end: writes one frame through the data port and enqueues it.
// Assumes the device end answers reads one cycle after the request.
`timescale 1ns/1ns
`default_nettype none
module htq_host
  import htq_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // User request: one frame of words
  input wire logic i_start,
  input wire logic [5:0] i_tag,
  input wire logic [10:0] i_length,
  input wire logic i_big_endian,
  input wire logic [15:0] i_word,
  output logic o_word_taken,
  output logic o_busy,
  // Host bus
  htq_bus_if.host bus
);
  import htq_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_SPACE, H_DMA, H_CTRL, H_LEN, H_DATA, H_ENQ, H_WAIT} htq_host_state_t;
  typedef struct packed {
    htq_host_state_t st;
    logic [10:0] words;
    logic [10:0] length;
    logic [5:0] tag;
    logic [8:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic taken;
    logic be;
    logic poll;
  } htq_host_s_t;
  htq_host_s_t s;
  htq_host_s_t next_s;
  always_comb
  begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    next_s.taken = 1'b0;
    next_s.poll = 1'b0;
    unique case (s.st)
      H_IDLE:
        if (i_start && i_length != 11'h000)
        begin
          next_s.length = i_length;
          next_s.tag = i_tag;
          next_s.be = i_big_endian;
          next_s.words = ((i_length + 11'h003) >> 2) << 1;
          next_s.wr = 1'b1;
          next_s.addr = REG_NEXT_SPACE;
          next_s.wdata = 16'(((i_length + 11'h007) >> 2));
          next_s.st = H_SPACE;
        end
      H_SPACE:
      begin
        next_s.wr = 1'b1;
        next_s.addr = REG_TXQ_COMMAND;
        next_s.wdata = 16'h0001 << TQC_SPACE_REQ;
        next_s.st = H_DMA;
      end
      H_DMA:
      begin
        next_s.wr = 1'b1;
        next_s.addr = REG_RXQ_CONTROL;
        next_s.wdata = 16'h0001 << RQC_DMA_START;
        next_s.st = H_CTRL;
      end
      H_CTRL:
      begin
        next_s.wr = 1'b1;
        next_s.addr = REG_DATA_PORT;
        next_s.wdata = {1'b1, 9'h000, s.tag};
        next_s.st = H_LEN;
      end
      H_LEN:
      begin
        next_s.wr = 1'b1;
        next_s.wdata = {5'h00, s.length};
        next_s.st = H_DATA;
      end
      H_DATA:
        if (s.words == 11'h000)
        begin
          next_s.wr = 1'b1;
          next_s.addr = REG_TXQ_COMMAND;
          next_s.wdata = 16'h0001 << TQC_ENQUEUE;
          next_s.st = H_ENQ;
        end
        else
        begin
          next_s.wr = 1'b1;
          next_s.wdata = s.be ? {i_word[7:0], i_word[15:8]} : i_word;
          next_s.taken = 1'b1;
          next_s.words = s.words - 11'h001;
        end
      H_ENQ:
      begin
        next_s.rd = 1'b1;
        next_s.addr = REG_TXQ_COMMAND;
        next_s.poll = 1'b1;
        next_s.st = H_WAIT;
      end
      H_WAIT:
        if (s.poll)
          next_s.st = H_WAIT;
        else if (bus.rdata[TQC_ENQUEUE] || bus.rdata[TQC_SPACE_REQ])
          next_s.st = H_ENQ;
        else
          next_s.st = H_IDLE;
    endcase
  end
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      s <= '0;
    else
      s <= next_s;
  end
  assign bus.addr = s.addr;
  assign bus.wr = s.wr;
  assign bus.rd = s.rd;
  assign bus.wdata = s.wdata;
  assign bus.big_endian = s.be;
  assign o_word_taken = s.taken;
  assign o_busy = s.st != H_IDLE;
endmodule : htq_host
`default_nettype wire

// ==== htq_props.sv ====
// Checker on the bus that joins the host end to the device end.
// Assumes it sits beside that interface on the same clock and reset.
`timescale 1ns/1ns
`default_nettype none
module htq_props
  import htq_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Bus
  input wire logic [8:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic big_endian
);
  import htq_pkg::*;
  logic dma;
  logic enq;
  logic spq;
  logic rdq;
  logic [7:0] wcnt;
  logic [10:0] len;
  logic [9:0] age;
  wire logic dw = wr && addr == REG_DATA_PORT;
  wire logic cw = wr && addr == REG_TXQ_COMMAND;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // A command bit counts as pending until a read shows it clear, since that is all the host can see.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      dma <= 1'b0;
      enq <= 1'b0;
      spq <= 1'b0;
      rdq <= 1'b0;
      wcnt <= 8'h00;
      len <= 11'h000;
      age <= 10'h000;
    end
    else
    begin
      rdq <= rd && addr == REG_TXQ_COMMAND;
      if (wr && addr == REG_RXQ_CONTROL)
        dma <= wdata[RQC_DMA_START];
      if (dw)
        wcnt <= wcnt + 8'h01;
      if (dw && wcnt == 8'h01)
        len <= wdata[LEN_HI:0];
      if (enq)
        age <= age + 10'h001;
      if (rdq && !rdata[TQC_ENQUEUE])
        enq <= 1'b0;
      if (rdq && !rdata[TQC_SPACE_REQ])
        spq <= 1'b0;
      if (cw && wdata[TQC_SPACE_REQ])
        spq <= 1'b1;
      if (cw && wdata[TQC_ENQUEUE])
      begin
        enq <= 1'b1;
        age <= 10'h000;
        wcnt <= 8'h00;
      end
    end
  end
  property p_data_needs_dma;
    dw |-> dma;
  endproperty
  a_data_needs_dma: assert property (p_data_needs_dma) else $error("data write without DMA access");
  property p_data_after_clear;
    dw |-> !enq;
  endproperty
  a_data_after_clear: assert property (p_data_after_clear) else $error("data write while enqueue pending");
  property p_length_word;
    dw && wcnt == 8'h01 && !big_endian |-> wdata[15:11] == 5'h00 && wdata[10:0] != 11'h000;
  endproperty
  a_length_word: assert property (p_length_word) else $error("bad length word");
  property p_frame_words;
    cw && wdata[TQC_ENQUEUE] && !big_endian |-> wcnt == 8'h02 + 8'(((12'(len) + 12'h003) >> 2) << 1);
  endproperty
  a_frame_words: assert property (p_frame_words) else $error("frame word count wrong");
  property p_space_once;
    cw && wdata[TQC_SPACE_REQ] |-> !spq;
  endproperty
  a_space_once: assert property (p_space_once) else $error("space request set while pending");
  // The host end only ever reads the command register, so that is where the read path is watched.
  property p_command_bits;
    rd && addr == REG_TXQ_COMMAND |=> rdata[15:2] == 14'h0000;
  endproperty
  a_command_bits: assert property (p_command_bits) else $error("command register upper bits set");
  property p_enq_reads_set;
    rd && addr == REG_TXQ_COMMAND && enq && age < 10'h004 |=> rdata[TQC_ENQUEUE];
  endproperty
  a_enq_reads_set: assert property (p_enq_reads_set) else $error("enqueue bit not set");
  property p_enq_bounded;
    enq |-> age < 10'h258;
  endproperty
  a_enq_bounded: assert property (p_enq_bounded) else $error("enqueue bit never cleared");
  c_enqueue: cover property (cw && wdata[TQC_ENQUEUE]);
  c_length: cover property (dw && wcnt == 8'h01);
  c_cleared: cover property (rdq && !rdata[TQC_ENQUEUE]);
endmodule : htq_props
`default_nettype wire

// ==== host_tx_queue_path_bench.sv ====
// Bench: host end and device end on one bus, plus a second device driven directly by tasks.
// Assumes the package, interface, design modules and props checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module host_tx_queue_path_bench;
  import htq_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic h_start = 1'b0;
  logic h_be = 1'b0;
  logic [5:0] h_tag = 6'h00;
  logic [10:0] h_len = 11'h001;
  logic [10:0] rx_len = 11'h000;
  logic [15:0] h_word = 16'h0000;
  logic [15:0] rx_stat = 16'h0000;
  logic [15:0] v;
  logic h_taken, h_busy, b_vld, b_last, b_err;
  logic got_last = 1'b0;
  logic [15:0] b_data, b_stat, b_lenw;
  logic [15:0] last_data = 16'h0000;
  logic [5:0] b_tag;
  logic [8:0] b_opt;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int n_tx = 0;
  int n_taken = 0;
  htq_bus_if bus_a();
  htq_bus_if bus_b();
  htq_host htq_host_inst (.i_clock(i_clock), .i_reset(i_reset), .i_start(h_start), .i_tag(h_tag),
    .i_length(h_len), .i_big_endian(h_be), .i_word(h_word), .o_word_taken(h_taken), .o_busy(h_busy), .bus(bus_a));
  htq_device htq_device_inst (.i_clock(i_clock), .i_reset(i_reset), .bus(bus_a), .o_tx_valid(), .o_tx_data(),
    .o_tx_last(), .o_tx_tag(), .o_tx_options(), .i_rx_status(rx_stat), .i_rx_length(rx_len),
    .o_rx_status_word(), .o_rx_length_word(), .o_rx_length_error());
  htq_device htq_device_b_inst (.i_clock(i_clock), .i_reset(i_reset), .bus(bus_b), .o_tx_valid(b_vld),
    .o_tx_data(b_data), .o_tx_last(b_last), .o_tx_tag(b_tag), .o_tx_options(b_opt), .i_rx_status(rx_stat),
    .i_rx_length(rx_len), .o_rx_status_word(b_stat), .o_rx_length_word(b_lenw), .o_rx_length_error(b_err));
  htq_props htq_props_inst (.i_clock(i_clock), .i_reset(i_reset), .addr(bus_a.addr), .wr(bus_a.wr),
    .rd(bus_a.rd), .wdata(bus_a.wdata), .rdata(bus_a.rdata), .big_endian(bus_a.big_endian));
  always #4 i_clock = ~i_clock;
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // The timeout is far above the few hundred cycles the scenarios need.
  always @(posedge i_clock)
  begin
    cycles++;
    if (b_vld)
    begin
      n_tx++;
      last_data <= b_data;
      got_last <= got_last | b_last;
    end
    if (h_taken)
    begin
      n_taken++;
      h_word <= h_word + 16'h0111;
    end
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic step;
    @(posedge i_clock);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr16(input logic [8:0] a, input logic [15:0] d);
    bus_b.addr = a;
    bus_b.wdata = d;
    bus_b.wr = 1'b1;
    step;
    bus_b.wr = 1'b0;
    step;
  endtask : wr16
  task automatic rd16(input logic [8:0] a);
    bus_b.addr = a;
    bus_b.rd = 1'b1;
    step;
    bus_b.rd = 1'b0;
    v = bus_b.rdata;
    step;
  endtask : rd16
  task automatic rdchk(input string what, input logic [8:0] a, input logic [15:0] m, input logic [15:0] e);
    rd16(a);
    chk(what, v & m, e);
  endtask : rdchk
  task automatic poll_clear(input int b);
    for (int k = 0; k < 80; k++)
    begin
      rd16(REG_TXQ_COMMAND);
      if (v[b] === 1'b0)
        break;
    end
    chk("command bit", {15'h0000, v[b]}, 16'h0000);
  endtask : poll_clear
  task automatic t_regs;
    rdchk("free at reset", REG_TX_FREE, 16'hFFFF, 16'h1800);
    wr16(REG_TX_CONTROL, 16'hFFFF);
    rdchk("control", REG_TX_CONTROL, 16'hFFFF, 16'h01EF);
    chk("options", {7'h00, b_opt}, 16'h01EF);
    rdchk("unmapped", 9'h1FE, 16'hFFFF, 16'h0000);
  endtask : t_regs
  task automatic t_space;
    wr16(REG_IRQ_MASK, 16'h4040);
    wr16(REG_NEXT_SPACE, 16'h0003);
    wr16(REG_TXQ_COMMAND, 16'h0002);
    rdchk("space flag", REG_IRQ_FLAGS, 16'h4040, 16'h0040);
    chk("irq on space", {15'h0000, bus_b.irq}, 16'h0001);
    poll_clear(TQC_SPACE_REQ);
    wr16(REG_IRQ_FLAGS, IRQ_CLEAR_ALL);
    rdchk("flags cleared", REG_IRQ_FLAGS, 16'hFFFF, 16'h0000);
    chk("irq cleared", {15'h0000, bus_b.irq}, 16'h0000);
  endtask : t_space
  task automatic t_frame;
    wr16(REG_DATA_PORT, 16'h5555);
    rdchk("free without DMA", REG_TX_FREE, 16'hFFFF, 16'h1800);
    wr16(REG_RXQ_CONTROL, 16'h0008);
    wr16(REG_TX_DATA_PTR, 16'h4000);
    rdchk("auto increment", REG_TX_DATA_PTR, 16'h4000, 16'h4000);
    wr16(REG_DATA_PORT, 16'h802A);
    wr16(REG_DATA_PORT, 16'h0005);
    for (int k = 1; k <= 4; k++)
      wr16(REG_DATA_PORT, 16'h1111 * 16'(k));
    rdchk("free after writes", REG_TX_FREE, 16'hFFFF, 16'h17F4);
    // Six accepted data-port writes of two bytes each move the pointer to 12.
    rdchk("pointer advanced", REG_TX_DATA_PTR, 16'hFFFF, 16'h400C);
    n_tx = 0;
    wr16(REG_TXQ_COMMAND, 16'h0001);
    poll_clear(TQC_ENQUEUE);
    chk("words sent", 16'(n_tx), 16'h0004);
    chk("last word", last_data, 16'h4444);
    chk("last marker", {15'h0000, got_last}, 16'h0001);
    chk("frame tag", {10'h000, b_tag}, 16'h002A);
    rdchk("free restored", REG_TX_FREE, 16'hFFFF, 16'h1800);
    rdchk("done flag", REG_IRQ_FLAGS, 16'h4000, 16'h4000);
    chk("irq on done", {15'h0000, bus_b.irq}, 16'h0001);
    wr16(REG_IRQ_FLAGS, IRQ_CLEAR_ALL);
  endtask : t_frame
  task automatic t_rx;
    rx_stat = 16'h1234;
    rx_len = 11'h064;
    step;
    step;
    chk("rx status", b_stat, 16'h1234);
    chk("rx length", b_lenw, 16'h0064);
    bus_b.big_endian = 1'b1;
    rx_len = 11'h7D1;
    step;
    step;
    chk("rx status swapped", b_stat, 16'h3412);
    chk("rx length swapped", b_lenw, 16'hD107);
    chk("rx too long", {15'h0000, b_err}, 16'h0001);
    rx_len = 11'h7D0;
    step;
    step;
    chk("rx at limit", {15'h0000, b_err}, 16'h0000);
    bus_b.big_endian = 1'b0;
  endtask : t_rx
  task automatic t_host(input logic [5:0] tag, input logic [10:0] len, input logic be, input int words);
    int t0;
    int k;
    t0 = n_taken;
    h_tag = tag;
    h_len = len;
    h_be = be;
    h_start = 1'b1;
    step;
    h_start = 1'b0;
    k = 0;
    while (h_busy !== 1'b0 && k < 900)
    begin
      step;
      k++;
    end
    chk("host done", {15'h0000, h_busy}, 16'h0000);
    chk("words taken", 16'(n_taken - t0), 16'(words));
  endtask : t_host
  initial
  begin
    bus_b.addr = 9'h000;
    bus_b.wr = 1'b0;
    bus_b.rd = 1'b0;
    bus_b.wdata = 16'h0000;
    bus_b.big_endian = 1'b0;
    step;
    step;
    i_reset = 1'b0;
    t_regs();
    t_space();
    t_frame();
    t_rx();
    t_host(6'h15, 11'h007, 1'b0, 4);
    t_host(6'h3F, 11'h001, 1'b1, 2);
    t_host(6'h01, 11'h008, 1'b0, 4);
    summarize();
  end
endmodule : host_tx_queue_path_bench
`default_nettype wire
